// File: verilog/servo_alarm_stop.v
// alarm, power-loss and stop-method protection logic
`timescale 1ns/1ns
`include "servo_stop_defs.vh"
// Overview of operation
// - uv select 0: servo off, on at return
// - uv select 1: power loss raises alarm trip
// - hold time 70..2000 ms, default 70
// - hold time 2000 disables power-off detection
// - alarm stop select picks decel and after-stop
// - 4..7 with stoppable alarm: immediate stop
// - 4..7 other alarm: brake or free-run fallback
// - error counter cleared on alarm reset
// - decel ends at 30 r/min, latched
// - allowable time expired while fast: alarm
// - non-stoppable alarm during immediate stop: alarm
// - immediate-stop overspeed raises second overspeed
// - both overspeeds: show first, no immediate stop
// - immediate-stop torque limit in three cases
// - torque 0..500, zero uses normal limit
// - overload level 115 when 0 or above
// - overspeed level defaults and clamps to ceiling
// - overrun beyond limit raises overrun error
// - control input sample period by code
// - immediate stop keeps servo on, active control
module servo_alarm_stop #(
    parameter MS_CYCLES = 50000,
    parameter IN_WIDTH = 4
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // register port
    input wire [3:0] addr,
    input wire [15:0] wdata,
    input wire wr,
    input wire rd,
    output reg [15:0] rdata,
    // power stage and feedback
    input wire mainPowerOk,
    input wire servoOnCmd,
    input wire [15:0] motorSpeed,
    input wire [15:0] maxSpeed,
    input wire [15:0] motorTorque,
    input wire [15:0] overrunTravel,
    input wire alarmIn,
    input wire alarmStoppable,
    input wire alarmReset,
    input wire driveProhibit,
    input wire [IN_WIDTH-1:0] ctrlInRaw,
    // outputs
    output reg servoOn,
    output reg dynBrake,
    output reg immStop,
    output reg torqueLimitIs,
    output reg [15:0] torqueLimit,
    output reg errClear,
    output reg alarmTrip,
    output reg [7:0] alarmCode,
    output wire [IN_WIDTH-1:0] ctrlIn
);
    // ------------------------------------------------------------
    // states and alarm codes
    // ------------------------------------------------------------
    localparam RUN = 3'h0;
    localparam DECEL = 3'h1;
    localparam ISTOP = 3'h2;
    localparam STOPPED = 3'h3;
    localparam ALARM = 3'h4;
    localparam PWROFF = 3'h5;

    localparam [7:0] AL_NONE = 8'h00;
    localparam [7:0] AL_UV = 8'h31;
    localparam [7:0] AL_OS1 = 8'h60;
    localparam [7:0] AL_OS2 = 8'h61;
    localparam [7:0] AL_OVLD = 8'h16;
    localparam [7:0] AL_OVRUN = 8'h34;
    localparam [7:0] AL_EXT = 8'hFF;

    // ------------------------------------------------------------
    // parameter registers
    // ------------------------------------------------------------
    reg uvSel_r;
    reg [1:0] dpSel_r;
    reg [3:0] pSel_r;
    reg [3:0] sSel_r;
    reg [15:0] hold_r;
    reg [2:0] aSel_r;
    reg [15:0] isTorq_r;
    reg [15:0] ovld_r;
    reg [15:0] ospd_r;
    reg [15:0] ovrun_r;
    reg [1:0] samp_r;
    reg [15:0] allow_r;
    reg [15:0] isOspd_r;
    reg [15:0] normTorq_r;

    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg coastDecel_r;
    reg freeAfter_r;
    reg [15:0] offCnt_r;
    reg [15:0] allowCnt_r;
    reg afterLatch_r;
    wire msTick;

    ms_tick #(.CYCLES(MS_CYCLES)) u_tick (
        .clk(clk),
        .rst(rst),
        .tick(msTick)
    );

    input_sampler #(.WIDTH(IN_WIDTH)) u_samp (
        .clk(clk),
        .rst(rst),
        .periodSel(samp_r),
        .rawIn(ctrlInRaw),
        .sampled(ctrlIn)
    );

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            uvSel_r <= `UVSEL_DEF;
            dpSel_r <= 2'h0;
            pSel_r <= 4'h0;
            sSel_r <= 4'h0;
            hold_r <= `HOLD_DEF;
            aSel_r <= 3'h0;
            isTorq_r <= 16'h0;
            ovld_r <= 16'h0;
            ospd_r <= 16'h0;
            ovrun_r <= `OVRUN_DEF;
            samp_r <= 2'h0;
            allow_r <= `ALLOW_DEF;
            isOspd_r <= 16'h0;
            normTorq_r <= 16'h01F4;
        end else if (wr) begin
            case (addr)
                `OFS_CTRL: begin
                    uvSel_r <= wdata[`CTRL_UVSEL];
                    dpSel_r <= wdata[2:1];
                    pSel_r <= wdata[6:3];
                    sSel_r <= wdata[10:7];
                end
                `OFS_HOLD: begin
                    // out-of-range writes clamp to range
                    if (wdata < `HOLD_MIN)
                        hold_r <= `HOLD_MIN;
                    else if (wdata > `HOLD_MAX)
                        hold_r <= `HOLD_MAX;
                    else
                        hold_r <= wdata;
                end
                `OFS_STOPSEL: aSel_r <= wdata[2:0];
                `OFS_ISTORQ: begin
                    if (wdata > `ISTORQ_MAX)
                        isTorq_r <= `ISTORQ_MAX;
                    else
                        isTorq_r <= wdata;
                end
                `OFS_OVLD: ovld_r <= wdata;
                `OFS_OSPD: ospd_r <= wdata;
                `OFS_OVRUN: ovrun_r <= wdata;
                `OFS_SAMPLE: samp_r <= wdata[1:0];
                `OFS_ALLOW: allow_r <= wdata;
                `OFS_ISOSPD: isOspd_r <= wdata;
                `OFS_RESET: normTorq_r <= wdata;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // effective detection levels
    // ------------------------------------------------------------
    wire [17:0] ceilWide = {2'h0, maxSpeed} + {2'h0, maxSpeed[15:0]} / 18'h5;
    wire [15:0] ospdCeil = ceilWide[17:16] != 2'h0 ? 16'hFFFF : ceilWide[15:0];
    wire [15:0] ospdEff = (ospd_r == 16'h0 || ospd_r > ospdCeil) ?
        ospdCeil : ospd_r;
    wire [15:0] ovldEff = (ovld_r == 16'h0 || ovld_r > `OVLD_CAP) ?
        `OVLD_CAP : ovld_r;
    wire os1 = motorSpeed > ospdEff;
    wire os2 = (state_r == ISTOP) && (motorSpeed > isOspd_r);
    wire ovld = motorTorque > ovldEff;
    wire ovrun = overrunTravel > ovrun_r;
    wire slow = motorSpeed <= `STOP_SPEED_RPM;
    // internal alarms do not support immediate stop except first overspeed
    wire intAlarm = os1 | os2 | ovld | ovrun;
    wire anyAlarm = intAlarm | alarmIn;
    // second overspeed beside first blocks immediate stop
    wire stoppable = os2 ? 1'b0 :
        (os1 & ~ovld & ~ovrun) | (alarmIn & alarmStoppable & ~intAlarm);
    wire detectOn = hold_r != `HOLD_MAX;
    wire powerLost = detectOn && !mainPowerOk && offCnt_r >= hold_r;

    // ------------------------------------------------------------
    // main power off timer
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (rst || mainPowerOk)
            offCnt_r <= 16'h0;
        else if (msTick && offCnt_r != 16'hFFFF)
            offCnt_r <= offCnt_r + 16'h1;
    end

    // allowable time counter for immediate stop, in ms
    always @(posedge clk) begin
        if (rst || state_r != ISTOP)
            allowCnt_r <= 16'h0;
        else if (msTick && allowCnt_r != 16'hFFFF)
            allowCnt_r <= allowCnt_r + 16'h1;
    end

    // ------------------------------------------------------------
    // stop state machine
    // ------------------------------------------------------------
    always @* begin
        state_nxt = state_r;
        case (state_r)
            RUN: begin
                if (anyAlarm) begin
                    if (aSel_r[2] && stoppable)
                        state_nxt = ISTOP;
                    else
                        state_nxt = DECEL;
                end else if (powerLost) begin
                    if (uvSel_r)
                        state_nxt = DECEL;
                    else
                        state_nxt = PWROFF;
                end
            end
            ISTOP: begin
                if (slow)
                    state_nxt = ALARM;
                else if (allowCnt_r >= allow_r)
                    state_nxt = ALARM;
                else if (intAlarm && !stoppable)
                    state_nxt = ALARM;
                else if (alarmIn && !alarmStoppable)
                    state_nxt = ALARM;
            end
            DECEL: begin
                if (slow)
                    state_nxt = ALARM;
            end
            ALARM: begin
                if (alarmReset && !anyAlarm)
                    state_nxt = RUN;
            end
            PWROFF: begin
                if (mainPowerOk)
                    state_nxt = RUN;
            end
            default: state_nxt = RUN;
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            state_r <= RUN;
            coastDecel_r <= 1'b0;
            freeAfter_r <= 1'b0;
            afterLatch_r <= 1'b0;
            alarmCode <= AL_NONE;
            errClear <= 1'b0;
        end else begin
            state_r <= state_nxt;
            errClear <= 1'b0;
            if (state_r == RUN && state_nxt != RUN) begin
                // sel 0..3: bit0 coast, bit1 free; 4..7 fallback
                coastDecel_r <= aSel_r[0];
                freeAfter_r <= aSel_r[1];
                if (state_nxt == PWROFF) begin
                    coastDecel_r <= pSel_r[0];
                    freeAfter_r <= pSel_r[1] | (pSel_r == 4'h9);
                end
                if (os1)
                    alarmCode <= AL_OS1;
                else if (os2)
                    alarmCode <= AL_OS2;
                else if (ovld)
                    alarmCode <= AL_OVLD;
                else if (ovrun)
                    alarmCode <= AL_OVRUN;
                else if (alarmIn)
                    alarmCode <= AL_EXT;
                else if (state_nxt == DECEL)
                    alarmCode <= AL_UV;
            end
            if (state_r == ISTOP && state_nxt == ALARM && os2)
                alarmCode <= os1 ? AL_OS1 : AL_OS2;
            if (state_nxt == ALARM)
                afterLatch_r <= 1'b1;
            if (state_r == ALARM && state_nxt == RUN) begin
                afterLatch_r <= 1'b0;
                alarmCode <= AL_NONE;
                errClear <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // power stage outputs
    // ------------------------------------------------------------
    wire tlCase = (driveProhibit && dpSel_r == 2'h2) ||
        (state_r == PWROFF && pSel_r[3]) ||
        (!servoOnCmd && sSel_r[3]);
    always @(posedge clk) begin
        if (rst) begin
            servoOn <= 1'b0;
            dynBrake <= 1'b0;
            immStop <= 1'b0;
            alarmTrip <= 1'b0;
            torqueLimitIs <= 1'b0;
            torqueLimit <= 16'h0;
        end else begin
            alarmTrip <= state_nxt == ALARM || state_nxt == DECEL ||
                state_nxt == ISTOP;
            immStop <= state_nxt == ISTOP;
            // immediate stop keeps control active
            servoOn <= (state_nxt == RUN && servoOnCmd) ||
                state_nxt == ISTOP;
            // first decel cycle: latched mode not yet loaded
            if (state_nxt == DECEL || state_nxt == PWROFF)
                dynBrake <= state_r != RUN ? !coastDecel_r :
                    state_nxt == PWROFF ? !pSel_r[0] : !aSel_r[0];
            else if (state_nxt == ALARM)
                dynBrake <= !freeAfter_r;
            else
                dynBrake <= 1'b0;
            torqueLimitIs <= state_nxt == ISTOP || tlCase;
            if ((state_nxt == ISTOP || tlCase) && isTorq_r != 16'h0)
                torqueLimit <= isTorq_r;
            else
                torqueLimit <= normTorq_r;
        end
    end

    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            rdata <= 16'h0;
        end else if (rd) begin
            case (addr)
                `OFS_CTRL: rdata <= {5'h0, sSel_r, pSel_r, dpSel_r, uvSel_r};
                `OFS_HOLD: rdata <= hold_r;
                `OFS_STOPSEL: rdata <= {13'h0, aSel_r};
                `OFS_ISTORQ: rdata <= isTorq_r;
                `OFS_OVLD: rdata <= ovld_r;
                `OFS_OSPD: rdata <= ospd_r;
                `OFS_OVRUN: rdata <= ovrun_r;
                `OFS_SAMPLE: rdata <= {14'h0, samp_r};
                `OFS_ALLOW: rdata <= allow_r;
                `OFS_ISOSPD: rdata <= isOspd_r;
                `OFS_STATUS: rdata <= {alarmCode, 4'h0, afterLatch_r,
                    state_r};
                `OFS_EFFECT: rdata <= ospdEff;
                `OFS_RESET: rdata <= normTorq_r;
                default: rdata <= 16'h0;
            endcase
        end else
            rdata <= 16'h0;
    end
endmodule

// File: verilog/servo_stop_defs.vh
// constants for the alarm and stop protection block
`ifndef SERVO_STOP_DEFS_VH
`define SERVO_STOP_DEFS_VH

// register offsets
`define OFS_CTRL 4'h0
`define OFS_HOLD 4'h1
`define OFS_STOPSEL 4'h2
`define OFS_ISTORQ 4'h3
`define OFS_OVLD 4'h4
`define OFS_OSPD 4'h5
`define OFS_OVRUN 4'h6
`define OFS_SAMPLE 4'h7
`define OFS_ALLOW 4'h8
`define OFS_ISOSPD 4'h9
`define OFS_STATUS 4'hA
`define OFS_EFFECT 4'hB
`define OFS_RESET 4'hC

// control register fields
`define CTRL_UVSEL 0
`define CTRL_DPSEL_LO 1
`define CTRL_PSEL_LO 3
`define CTRL_SSEL_LO 7

// reset values and hold time range
`define HOLD_DEF 16'h0046
`define HOLD_MIN 16'h0046
`define HOLD_MAX 16'h07D0
`define OVRUN_DEF 16'h000A
`define UVSEL_DEF 1'b1
`define ALLOW_DEF 16'h00C8

// speed and level constants
`define STOP_SPEED_RPM 16'h001E
`define OVLD_CAP 16'h0073
`define ISTORQ_MAX 16'h01F4

// timing
`define CLK_HZ 50000000
`define MS_NS 1000000
`define CLK_NS 20
`define CYC_PER_MS (`MS_NS / `CLK_NS)
`define SAMP0_US 166
`define SAMP1_US 333
`define SAMP2_US 1000
`define SAMP3_US 1666
`define US_CYC(u) (((u) * 1000) / `CLK_NS)

`endif

// File: verilog/ms_tick.v
// millisecond tick generator
`timescale 1ns/1ns
module ms_tick #(
    parameter CYCLES = 50000
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // tick out
    output reg tick
);
    reg [31:0] cnt_r;

    always @(posedge clk) begin
        if (rst) begin
            cnt_r <= 32'h0;
            tick <= 1'b0;
        end else if (cnt_r == CYCLES - 1) begin
            cnt_r <= 32'h0;
            tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 32'h1;
            tick <= 1'b0;
        end
    end
endmodule

// File: verilog/input_sampler.v
// control input sampling at a selectable period
`timescale 1ns/1ns
`include "servo_stop_defs.vh"
module input_sampler #(
    parameter WIDTH = 4
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // period code and raw inputs
    input wire [1:0] periodSel,
    input wire [WIDTH-1:0] rawIn,
    // sampled inputs
    output reg [WIDTH-1:0] sampled
);
    localparam [31:0] P0 = `US_CYC(`SAMP0_US);
    localparam [31:0] P1 = `US_CYC(`SAMP1_US);
    localparam [31:0] P2 = `US_CYC(`SAMP2_US);
    localparam [31:0] P3 = `US_CYC(`SAMP3_US);
    reg [31:0] cnt_r;
    reg [31:0] period;

    always @* begin
        case (periodSel)
            2'h0: period = P0;
            2'h1: period = P1;
            2'h2: period = P2;
            default: period = P3;
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            cnt_r <= 32'h0;
            sampled <= {WIDTH{1'b0}};
        end else if (cnt_r >= period - 32'h1) begin
            cnt_r <= 32'h0;
            sampled <= rawIn;
        end else begin
            cnt_r <= cnt_r + 32'h1;
        end
    end
endmodule

// File: tb/servo_alarm_stop_assertions.sv
// assertion checker for the alarm and stop block
`timescale 1ns/1ns
module servo_alarm_stop_assertions (
    // clock and reset
    input wire clk,
    input wire rst,
    // watched ports
    input wire rd,
    input wire [15:0] rdata,
    input wire alarmReset,
    input wire servoOn,
    input wire dynBrake,
    input wire immStop,
    input wire [15:0] torqueLimit,
    input wire errClear,
    input wire alarmTrip
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ----
    // properties
    // ----
    read_slot_a: assert property (!$past(rd) |-> rdata == 16'h0000)
        else $error("read data outside its slot");
    imm_active_a: assert property (immStop |-> servoOn && !dynBrake)
        else $error("immediate stop without servo control");
    brake_off_a: assert property (dynBrake |-> !servoOn)
        else $error("brake applied with servo on");
    clear_pulse_a: assert property (errClear |=> !errClear)
        else $error("error clear longer than one cycle");
    clear_run_a: assert property (errClear |-> !immStop)
        else $error("error clear during immediate stop");
    trip_latch_a: assert property ($fell(alarmTrip) |->
        $past(alarmReset) || $past(alarmReset, 2))
        else $error("trip dropped without reset");
    trip_stage_a: assert property (alarmTrip && $past(alarmTrip)
        && !immStop |-> !servoOn)
        else $error("servo on while tripped");
    torque_cap_a: assert property (torqueLimit <= 16'h01F4)
        else $error("torque limit above ceiling");
    // ----
    // coverage
    // ----
    cover property ($rose(immStop));
    cover property ($rose(errClear));
    cover property ($rose(alarmTrip) ##1 alarmTrip[*2]);
endmodule

bind servo_alarm_stop servo_alarm_stop_assertions chk (.clk(clk),
    .rst(rst), .rd(rd), .rdata(rdata), .alarmReset(alarmReset),
    .servoOn(servoOn), .dynBrake(dynBrake), .immStop(immStop),
    .torqueLimit(torqueLimit), .errClear(errClear), .alarmTrip(alarmTrip));

// File: tb/motor_model.sv
// behavioural motor with speed feedback
`timescale 1ns/1ns
module motor_model (
    // clock
    input wire clk,
    // drive state
    input wire servoOn,
    input wire immStop,
    input wire dynBrake,
    input wire [15:0] target,
    // feedback
    output reg [15:0] speed
);
    // distinct rates so each stop method shows in the timing
    function [15:0] dec(input [15:0] s, input [15:0] d);
        dec = (s > d) ? s - d : 16'h0000;
    endfunction
    initial speed = 16'h0000;
    always @(posedge clk) begin
        if (immStop) begin
            speed <= dec(speed, 16'h0005);
        end else if (servoOn) begin
            speed <= target;
        end else if (dynBrake) begin
            speed <= dec(speed, 16'h0004);
        end else begin
            speed <= dec(speed, 16'h0002);
        end
    end
endmodule

// File: tb/servo_alarm_stop_tb.sv
// self-checking bench for the alarm and stop block
`timescale 1ns/1ns
module servo_alarm_stop_tb;
    // ----
    // stimulus and observation
    // ----
    reg clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rdSeen_r = 1'b0;
    reg [3:0] addr = 4'h0, ctrlInRaw = 4'h0;
    reg [15:0] wdata = 16'h0000, motorTorque = 16'h0000, v;
    reg [15:0] overrunTravel = 16'h0000, rnd = 16'hB624;
    reg mainPowerOk = 1'b1, servoOnCmd = 1'b1, alarmIn = 1'b0;
    reg alarmStoppable = 1'b0, alarmReset = 1'b0, driveProhibit = 1'b0;
    reg [2:0] sel;
    reg stp, imm;
    wire servoOn, dynBrake, immStop, torqueLimitIs, errClear, alarmTrip;
    wire [15:0] rdata, torqueLimit, motorSpeed;
    wire [7:0] alarmCode;
    wire [3:0] ctrlIn;
    integer miscompares = 0, num_checks = 0, k, n;
    reg [15:0] expQ [$];
    always #10 clk = ~clk;
    servo_alarm_stop #(.MS_CYCLES(10), .IN_WIDTH(4)) dut (.clk(clk),
        .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .mainPowerOk(mainPowerOk), .servoOnCmd(servoOnCmd),
        .motorSpeed(motorSpeed), .maxSpeed(16'h0BB8),
        .motorTorque(motorTorque), .overrunTravel(overrunTravel),
        .alarmIn(alarmIn), .alarmStoppable(alarmStoppable),
        .alarmReset(alarmReset), .driveProhibit(driveProhibit),
        .ctrlInRaw(ctrlInRaw), .servoOn(servoOn), .dynBrake(dynBrake),
        .immStop(immStop), .torqueLimitIs(torqueLimitIs),
        .torqueLimit(torqueLimit), .errClear(errClear),
        .alarmTrip(alarmTrip), .alarmCode(alarmCode), .ctrlIn(ctrlIn));
    motor_model motor (.clk(clk), .servoOn(servoOn), .immStop(immStop),
        .dynBrake(dynBrake), .target(16'h03E8), .speed(motorSpeed));
    // ----
    // helpers
    // ----
    function [15:0] lfsr(input [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function pick(input integer i);
        pick = i == 0 ? servoOn : i == 1 ? dynBrake : i == 2 ? immStop :
            i == 3 ? alarmTrip : errClear;
    endfunction
    task automatic check(input [15:0] got, input [15:0] exp);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task summarize;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task wreg(input [3:0] a, input [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        rd <= 1'b0;
        @(posedge clk);
    endtask
    task rreg(input [3:0] a, input [15:0] e);
        addr <= a;
        rd <= 1'b1;
        wr <= 1'b0;
        expQ.push_back(e);
        @(posedge clk);
    endtask
    // strobes drop here so no task lowers and raises in one step
    task quiet;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    endtask
    task wrd(input [3:0] a, input [15:0] d, input [3:0] b, input [15:0] e);
        wreg(a, d);
        quiet;
        rreg(b, e);
        quiet;
    endtask
    task waitBit(input integer i, input b, input integer lim);
        for (n = 0; pick(i) !== b && n < lim; n = n + 1) @(posedge clk);
        check({15'h0000, pick(i)}, {15'h0000, b});
    endtask
    task waitSpeed(input [15:0] lvl);
        for (n = 0; motorSpeed > lvl && n < 1200; n = n + 1) @(posedge clk);
    endtask
    task clrAlarm;
        alarmIn <= 1'b0;
        waitSpeed(16'h0000);
        alarmReset <= 1'b1;
        @(posedge clk);
        alarmReset <= 1'b0;
        waitBit(4, 1'b1, 20);
        waitBit(3, 1'b0, 20);
        waitBit(0, 1'b1, 20);
    endtask
    // read data stands only in the cycle after the strobe
    always @(posedge clk) begin
        rdSeen_r <= rd;
        if (rdSeen_r) begin
            check(rdata, expQ.pop_front());
        end
    end
    initial begin
        repeat (95000) @(posedge clk);
        miscompares = miscompares + 1;
        summarize;
    end
    // ----
    // test sequence
    // ----
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        rreg(4'h0, 16'h0001);
        rreg(4'h1, 16'h0046);
        rreg(4'h6, 16'h000A);
        rreg(4'h7, 16'h0000);
        rreg(4'hB, 16'h0E10);
        rreg(4'hD, 16'h0000);
        quiet;
        wrd(4'h1, 16'h0005, 4'h1, 16'h0046);
        wrd(4'h1, 16'h0BB8, 4'h1, 16'h07D0);
        wrd(4'h3, 16'h0258, 4'h3, 16'h01F4);
        wrd(4'h5, 16'h4E20, 4'hB, 16'h0E10);
        rnd = lfsr(rnd);
        // stay above running speed so no overspeed trips here
        v = {2'b00, rnd[13:0]} | 16'h0400;
        wrd(4'h5, v, 4'hB, (v == 0 || v > 16'h0E10) ? 16'h0E10 : v);
        wrd(4'hD, 16'h1234, 4'hD, 16'h0000);
        wreg(4'h1, 16'h0046);
        wrd(4'h5, 16'h0000, 4'h5, 16'h0000);
        wreg(4'h9, 16'h4E20);
        quiet;
        $display("registers done");
        for (k = 0; k < 12; k = k + 1) begin
            sel = (k < 8) ? k[2:0] : k[2:0] + 3'h4;
            stp = k < 8;
            imm = sel[2] & stp;
            wreg(4'h2, {13'h0000, sel});
            quiet;
            alarmStoppable <= stp;
            alarmIn <= 1'b1;
            repeat (4) @(posedge clk);
            check({13'h0000, servoOn, dynBrake, immStop},
                {13'h0000, imm, ~imm & ~sel[0], imm});
            waitSpeed(16'h001E);
            repeat (4) @(posedge clk);
            check({12'h000, servoOn, dynBrake, immStop, alarmTrip},
                {13'h0000, ~sel[1], 2'b01});
            check({8'h00, alarmCode}, 16'h00FF);
            clrAlarm;
        end
        $display("stop methods done");
        for (k = 0; k < 2; k = k + 1) begin
            wreg(4'h2, 16'h0004);
            wreg(k ? 4'h8 : 4'h9, k ? 16'h0005 : 16'h0384);
            quiet;
            alarmStoppable <= 1'b1;
            alarmIn <= 1'b1;
            waitBit(2, 1'b1, 10);
            waitBit(2, 1'b0, k ? 90 : 15);
            waitBit(3, 1'b1, 3);
            if (k == 0) check({8'h00, alarmCode}, 16'h0061);
            wreg(4'h9, 16'h4E20);
            wreg(4'h8, 16'h00C8);
            quiet;
            clrAlarm;
        end
        wreg(4'h2, 16'h0000);
        wreg(4'h4, 16'h00C8);
        quiet;
        overrunTravel <= 16'h000B;
        waitBit(3, 1'b1, 100);
        check({8'h00, alarmCode}, 16'h0034);
        overrunTravel <= 16'h000A;
        clrAlarm;
        motorTorque <= 16'h0078;
        waitBit(3, 1'b1, 2000);
        check({8'h00, alarmCode}, 16'h0016);
        motorTorque <= 16'h0000;
        clrAlarm;
        $display("trips done");
        mainPowerOk <= 1'b0;
        repeat (640) @(posedge clk);
        check({15'h0000, alarmTrip}, 16'h0000);
        waitBit(3, 1'b1, 150);
        check({8'h00, alarmCode}, 16'h0031);
        mainPowerOk <= 1'b1;
        clrAlarm;
        wreg(4'h1, 16'h07D0);
        quiet;
        mainPowerOk <= 1'b0;
        repeat (800) @(posedge clk);
        check({15'h0000, alarmTrip}, 16'h0000);
        mainPowerOk <= 1'b1;
        wreg(4'h1, 16'h0046);
        wreg(4'h0, 16'h0000);
        quiet;
        mainPowerOk <= 1'b0;
        waitBit(0, 1'b0, 800);
        check({15'h0000, alarmTrip}, 16'h0000);
        mainPowerOk <= 1'b1;
        waitBit(0, 1'b1, 800);
        $display("power loss done");
        for (k = 0; k < 3; k = k + 1) begin
            wreg(4'h0, k == 1 ? 16'h0005 : 16'h0401);
            wreg(4'h3, k == 2 ? 16'h0000 : 16'h012C);
            quiet;
            servoOnCmd <= k == 1;
            driveProhibit <= k == 1;
            repeat (4) @(posedge clk);
            check(torqueLimit, k == 2 ? 16'h01F4 : 16'h012C);
            check({15'h0000, torqueLimitIs}, 16'h0001);
            servoOnCmd <= 1'b1;
            driveProhibit <= 1'b0;
            waitSpeed(16'h0000);
            waitBit(0, 1'b1, 600);
        end
        wreg(4'h0, 16'h0001);
        quiet;
        $display("torque limit done");
        for (k = 0; k < 2; k = k + 1) begin
            wreg(4'h7, k);
            quiet;
            rnd = lfsr(rnd);
            ctrlInRaw <= ctrlIn ^ (rnd[3:0] | 4'h1);
            @(posedge clk);
            for (n = 0; ctrlIn !== ctrlInRaw && n < 40000; n = n + 1)
                @(posedge clk);
            check({12'h000, ctrlIn}, {12'h000, ctrlInRaw});
            // one read period is 8300 or 16650 cycles at 20 ns
            check({15'h0000, n < (k ? 16652 : 8302)}, 16'h0001);
        end
        $display("sampling done");
        summarize;
    end
endmodule
